// >>> pmes_pkg.sv
// constants for the performance-event signalling block
// assumes one core clock; no software-visible registers
package pmes_pkg;
  // event codes as counted by the internal counters
  localparam logic [7:0] PMES_EVT_PC_CHANGE  = 8'h0c;
  localparam logic [7:0] PMES_EVT_IMM_BRANCH = 8'h0d;
  localparam logic [7:0] PMES_EVT_BARRIER    = 8'h90;
  localparam logic [7:0] PMES_EVT_SIMD_REN   = 8'h74;
  localparam logic [7:0] PMES_EVT_INSTR_REN  = 8'h68;

  // field positions on the external event bus
  localparam int PMES_BUS_W          = 58;
  localparam int PMES_PC_CHANGE_BIT  = 13;
  localparam int PMES_IMM_BRANCH_BIT = 14;
  localparam int PMES_SIMD_LO        = 37;
  localparam int PMES_SIMD_HI        = 38;
  localparam int PMES_REN_LO         = 8;
  localparam int PMES_REN_HI         = 9;

  // rename stage width and reset values
  localparam int         PMES_LANES   = 2;
  localparam logic       PMES_RST_BIT = 1'b0;
  localparam logic [1:0] PMES_RST_CNT = 2'h0;
endpackage : pmes_pkg

// >>> pmes_lane_count.sv
// two-lane population count for one event bus count field
// assumes lanes are already qualified by the caller
`timescale 1ns/1ps
module pmes_lane_count
  import pmes_pkg::*;
(
  input  wire logic [1:0] lanes,
  output wire logic [1:0] count
);
  assign count = {lanes[1] & lanes[0], lanes[1] ^ lanes[0]};
endmodule : pmes_lane_count

// >>> pmes_event_signal.sv
// performance-event generation and external event bus driver
// assumes per-cycle inputs from the execute and rename stages, synchronous to clk
// Operation
// - an executed barrier raises both pc-change and immediate-branch events
// - pc-change drives bus bit 13, immediate-branch bit 14, both on barriers
// - a separate event marks every executed barrier for software correction
// - simd rename event ignores stalls, so held instructions count each cycle
// - simd rename count also appears on bus bits 38:37, same over-count
// - rename instruction event counts passing instructions, may miss branch-type ones
// - rename instruction count appears on bus bits 9:8, wrong when hidden
// - loss needs enable, event in use, a stall, and a hideable instruction
`timescale 1ns/1ps
module pmes_event_signal
  import pmes_pkg::*;
#(
  parameter int BUS_W = PMES_BUS_W
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             events_en,
  input  wire logic             rename_evt_used,
  input  wire logic             exec_pc_change,
  input  wire logic             exec_imm_branch,
  input  wire logic             exec_barrier,
  input  wire logic [1:0]       rename_valid,
  input  wire logic [1:0]       rename_simd,
  input  wire logic [1:0]       rename_hideable,
  input  wire logic             rename_stall,
  output logic      [BUS_W-1:0] perf_event_bus,
  output logic                  barrier_event
);
  logic [BUS_W-1:0] bus_q;
  logic [BUS_W-1:0] bus_d;
  logic             barrier_q;
  logic             stall_q;

  wire logic       pc_change_evt;
  wire logic       imm_branch_evt;
  wire logic       barrier_evt;
  wire logic [1:0] simd_lanes;
  wire logic [1:0] pass_lanes;
  wire logic [1:0] hidden_lanes;
  wire logic [1:0] ren_lanes;
  wire logic       loss_armed;
  wire logic [1:0] simd_cnt;
  wire logic [1:0] ren_cnt;

  // barrier is a branch internally, so it leaks into both events
  assign pc_change_evt  = events_en & (exec_pc_change | exec_barrier);
  assign imm_branch_evt = events_en & (exec_imm_branch | exec_barrier);
  assign barrier_evt    = events_en & exec_barrier;

  // stall not consulted: a held instruction is counted every cycle
  assign simd_lanes = rename_valid & rename_simd & {2{events_en}};

  // a stall in the previous cycle can hide branch-type instructions now
  assign pass_lanes   = rename_valid & ~{2{rename_stall}} & {2{events_en}};
  assign loss_armed   = events_en & rename_evt_used & stall_q;
  assign hidden_lanes = pass_lanes & rename_hideable & {2{loss_armed}};
  assign ren_lanes    = pass_lanes & ~hidden_lanes;

  pmes_lane_count u_simd_cnt (
    .lanes (simd_lanes),
    .count (simd_cnt)
  );

  pmes_lane_count u_ren_cnt (
    .lanes (ren_lanes),
    .count (ren_cnt)
  );

  always_comb begin
    bus_d = '0;
    bus_d[PMES_PC_CHANGE_BIT]           = pc_change_evt;
    bus_d[PMES_IMM_BRANCH_BIT]          = imm_branch_evt;
    bus_d[PMES_SIMD_HI:PMES_SIMD_LO]    = simd_cnt;
    bus_d[PMES_REN_HI:PMES_REN_LO]      = ren_cnt;
  end

  // registered so an outside counter samples clean one-cycle values
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_q     <= '0;
      barrier_q <= PMES_RST_BIT;
      stall_q   <= PMES_RST_BIT;
    end else begin
      bus_q     <= bus_d;
      barrier_q <= barrier_evt;
      stall_q   <= rename_stall;
    end
  end

  assign perf_event_bus = bus_q;
  assign barrier_event  = barrier_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // reference built from the ports only, so a broken datapath wire
  // cannot vouch for itself
  function automatic logic [1:0] lane_pop(input logic [1:0] lanes);
    return {1'b0, lanes[0]} + {1'b0, lanes[1]};
  endfunction : lane_pop

  function automatic logic [BUS_W-1:0] bus_used_mask();
    logic [BUS_W-1:0] m;
    m = '0;
    m[PMES_PC_CHANGE_BIT]        = 1'b1;
    m[PMES_IMM_BRANCH_BIT]       = 1'b1;
    m[PMES_SIMD_HI:PMES_SIMD_LO] = 2'h3;
    m[PMES_REN_HI:PMES_REN_LO]   = 2'h3;
    return m;
  endfunction : bus_used_mask

  wire logic [1:0]       ref_simd_lanes;
  wire logic [1:0]       ref_pass_lanes;
  wire logic [1:0]       ref_hide_lanes;
  wire logic             ref_loss;
  wire logic [BUS_W-1:0] spare_bits;

  logic [1:0] exp_simd_q;
  logic [1:0] exp_pass_q;
  logic [1:0] exp_ren_q;
  logic       exp_pc_q;
  logic       exp_ib_q;
  logic       exp_bar_q;
  logic       ref_stall_q;

  assign ref_simd_lanes = rename_valid & rename_simd & {2{events_en}};
  assign ref_pass_lanes = rename_valid & {2{events_en & ~rename_stall}};
  assign ref_loss       = events_en & rename_evt_used & ref_stall_q;
  assign ref_hide_lanes = ref_pass_lanes & rename_hideable & {2{ref_loss}};
  assign spare_bits     = perf_event_bus & ~bus_used_mask();

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      exp_simd_q  <= PMES_RST_CNT;
      exp_pass_q  <= PMES_RST_CNT;
      exp_ren_q   <= PMES_RST_CNT;
      exp_pc_q    <= PMES_RST_BIT;
      exp_ib_q    <= PMES_RST_BIT;
      exp_bar_q   <= PMES_RST_BIT;
      ref_stall_q <= PMES_RST_BIT;
    end else begin
      exp_simd_q  <= lane_pop(ref_simd_lanes);
      exp_pass_q  <= lane_pop(ref_pass_lanes);
      exp_ren_q   <= lane_pop(ref_pass_lanes & ~ref_hide_lanes);
      exp_pc_q    <= events_en & (exec_pc_change | exec_barrier);
      exp_ib_q    <= events_en & (exec_imm_branch | exec_barrier);
      exp_bar_q   <= events_en & exec_barrier;
      ref_stall_q <= rename_stall;
    end
  end

  a_barrier_pc_change: assert property (
    events_en && exec_barrier |=> perf_event_bus[PMES_PC_CHANGE_BIT])
    else $error("barrier did not raise pc-change bit");
  a_barrier_both_bits: assert property (
    events_en && exec_barrier |=>
      perf_event_bus[PMES_IMM_BRANCH_BIT] && perf_event_bus[PMES_PC_CHANGE_BIT])
    else $error("barrier did not raise both branch bits");
  a_barrier_event_tie: assert property (
    barrier_event |-> perf_event_bus[PMES_PC_CHANGE_BIT] && perf_event_bus[PMES_IMM_BRANCH_BIT])
    else $error("barrier event without branch bits");
  a_simd_stall_count: assert property (
    (events_en && rename_stall && (rename_valid & rename_simd) == 2'h3) [*2] |=>
      perf_event_bus[PMES_SIMD_HI:PMES_SIMD_LO] == 2'h2)
    else $error("stalled simd instructions not recounted");
  a_simd_field_value: assert property (
    ##1 perf_event_bus[PMES_SIMD_HI:PMES_SIMD_LO] == exp_simd_q)
    else $error("simd field mismatch");
  a_rename_no_loss: assert property (
    !stall_q |=> perf_event_bus[PMES_REN_HI:PMES_REN_LO] == exp_pass_q)
    else $error("rename count low without stall");
  a_rename_hidden_zero: assert property (
    events_en && rename_evt_used && stall_q && !rename_stall &&
      (rename_valid & ~rename_hideable) == 2'h0 |=>
      perf_event_bus[PMES_REN_HI:PMES_REN_LO] == 2'h0)
    else $error("hidden instructions were counted");
  a_rename_unused_exact: assert property (
    !rename_evt_used |=> perf_event_bus[PMES_REN_HI:PMES_REN_LO] == exp_pass_q)
    else $error("loss without event in use");
  a_bus_quiet_disabled: assert property (
    !events_en |=> perf_event_bus == '0 && !barrier_event)
    else $error("bus active while events disabled");
  a_pulse_one_cycle: assert property (
    events_en && exec_barrier ##1 !exec_barrier && !exec_pc_change |=>
      !perf_event_bus[PMES_PC_CHANGE_BIT])
    else $error("pc-change bit held past its cycle");

  a_pc_bit_exact: assert property (
    perf_event_bus[PMES_PC_CHANGE_BIT] == exp_pc_q)
    else $error("pc-change bit differs from its events");
  a_ib_bit_exact: assert property (
    perf_event_bus[PMES_IMM_BRANCH_BIT] == exp_ib_q)
    else $error("immediate-branch bit differs from its events");
  a_imm_branch_alone: assert property (
    events_en && exec_imm_branch && !exec_barrier && !exec_pc_change |=>
      perf_event_bus[PMES_IMM_BRANCH_BIT] && !perf_event_bus[PMES_PC_CHANGE_BIT])
    else $error("immediate branch leaked into pc-change bit");
  a_barrier_exact: assert property (
    barrier_event == exp_bar_q)
    else $error("barrier event differs from executed barriers");
  a_simd_ignores_stall: assert property (
    events_en && rename_stall && (rename_valid & rename_simd) != 2'h0 |=>
      perf_event_bus[PMES_SIMD_HI:PMES_SIMD_LO] != 2'h0)
    else $error("stalled simd instruction not counted");
  a_rename_stalled_zero: assert property (
    events_en && rename_stall |=> perf_event_bus[PMES_REN_HI:PMES_REN_LO] == 2'h0)
    else $error("stalled instruction counted as passing");
  a_rename_never_high: assert property (
    perf_event_bus[PMES_REN_HI:PMES_REN_LO] <= exp_pass_q)
    else $error("rename field above passing instructions");
  a_rename_field_exact: assert property (
    perf_event_bus[PMES_REN_HI:PMES_REN_LO] == exp_ren_q)
    else $error("rename field differs from expected count");
  a_bus_spare_zero: assert property (
    spare_bits == '0)
    else $error("unassigned bus bit set");

  c_barrier_seen: cover property (events_en && exec_barrier ##1 barrier_event);
  c_simd_stalled: cover property ((events_en && rename_stall && rename_simd[0]) [*3]);
  c_rename_loss: cover property (events_en && rename_evt_used && stall_q && |hidden_lanes);
  c_dual_rename: cover property (perf_event_bus[PMES_REN_HI:PMES_REN_LO] == 2'h2);
  c_imm_only: cover property (events_en && exec_imm_branch && !exec_barrier ##1
    perf_event_bus[PMES_IMM_BRANCH_BIT]);
endmodule : pmes_event_signal

// >>> pmes_event_counter.sv
// external counter model that sums the event bus simd count field (bits 38:37) only
// assumes the bus is registered on the same core clock
`timescale 1ns/1ps
module pmes_event_counter
  import pmes_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic [PMES_BUS_W-1:0] perf_event_bus,
  output logic      [7:0]            simd_total
);
  // sampled on every edge, since each field stands for one cycle only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      simd_total <= 8'h00;
    end else begin
      simd_total <= simd_total + 8'(perf_event_bus[PMES_SIMD_HI:PMES_SIMD_LO]);
    end
  end
endmodule : pmes_event_counter

// >>> pmes_event_signal_test.sv
// self-checking bench for the event signalling block
// assumes the counter model sits on the bus; inputs change at falling edges
`timescale 1ns/1ps
module pmes_event_signal_test
  import pmes_pkg::*;
;
  logic                  clk, rst_n, en, used, pc, ib, bar, st;
  logic [1:0]            v, s, h;
  logic [PMES_BUS_W-1:0] bus;
  logic                  bev;
  logic [7:0]            tot, t0;
  int                    err_total = 0;
  int                    cmp_count = 0;
  pmes_event_signal dut_u (.clk(clk), .rst_n(rst_n), .events_en(en), .rename_evt_used(used),
    .exec_pc_change(pc), .exec_imm_branch(ib), .exec_barrier(bar), .rename_valid(v),
    .rename_simd(s), .rename_hideable(h), .rename_stall(st), .perf_event_bus(bus),
    .barrier_event(bev));
  pmes_event_counter cnt_u (.clk(clk), .rst_n(rst_n), .perf_event_bus(bus), .simd_total(tot));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [63:0] mk(logic p, logic i, logic [1:0] sc, logic [1:0] rc);
    logic [63:0] e;
    e = 64'h0;
    e[PMES_PC_CHANGE_BIT] = p;
    e[PMES_IMM_BRANCH_BIT] = i;
    e[PMES_SIMD_HI:PMES_SIMD_LO] = sc;
    e[PMES_REN_HI:PMES_REN_LO] = rc;
    return e;
  endfunction : mk
  // one cycle of inputs; outputs are settled by the next falling edge
  task automatic step(logic a, b, c, d, e, logic [1:0] vv, ss, hh, logic t);
    {en, used, pc, ib, bar, v, s, h, st} = {a, b, c, d, e, vv, ss, hh, t};
    @(negedge clk);
  endtask : step
  task automatic t_barrier();
    step(1, 0, 1, 0, 0, 2'h0, 2'h0, 2'h0, 0);
    chk(64'(bus), mk(1, 0, 2'h0, 2'h0));
    chk(64'(bev), 64'h0);
    step(1, 0, 0, 0, 1, 2'h0, 2'h0, 2'h0, 0);
    chk(64'(bus), mk(1, 1, 2'h0, 2'h0));
    chk(64'(bev), 64'h1);
    step(1, 0, 0, 1, 0, 2'h0, 2'h0, 2'h0, 0);
    chk(64'(bus), mk(0, 1, 2'h0, 2'h0));
    chk(64'(bev), 64'h0);
    step(1, 0, 0, 0, 0, 2'h0, 2'h0, 2'h0, 0);
    chk(64'(bus), mk(0, 0, 2'h0, 2'h0));
    chk(64'(bev), 64'h0);
    step(0, 1, 1, 1, 1, 2'h3, 2'h3, 2'h0, 0);
    chk(64'(bus), 64'h0);
    chk(64'(bev), 64'h0);
    $display("test barrier done");
  endtask : t_barrier
  task automatic t_simd();
    t0 = tot;
    // stalled pair held three cycles is counted three times
    repeat (3) begin
      step(1, 0, 0, 0, 0, 2'h3, 2'h3, 2'h0, 1);
      chk(64'(bus), mk(0, 0, 2'h2, 2'h0));
    end
    step(1, 0, 0, 0, 0, 2'h0, 2'h0, 2'h0, 0);
    chk(64'(tot - t0), 64'h6);
    $display("test simd done");
  endtask : t_simd
  task automatic t_hide();
    step(1, 1, 0, 0, 0, 2'h1, 2'h0, 2'h0, 1);
    chk(64'(bus), mk(0, 0, 2'h0, 2'h0));
    step(1, 1, 0, 0, 0, 2'h1, 2'h0, 2'h1, 0);
    chk(64'(bus), mk(0, 0, 2'h0, 2'h0));
    step(1, 0, 0, 0, 0, 2'h1, 2'h0, 2'h0, 1);
    step(1, 0, 0, 0, 0, 2'h1, 2'h0, 2'h1, 0);
    chk(64'(bus), mk(0, 0, 2'h0, 2'h1));
    step(1, 1, 0, 0, 0, 2'h3, 2'h0, 2'h1, 0);
    chk(64'(bus), mk(0, 0, 2'h0, 2'h2));
    step(1, 0, 0, 0, 0, 2'h0, 2'h0, 2'h0, 0);
    $display("test hide done");
  endtask : t_hide
  // mid-run reset clears outputs and the stall history
  task automatic t_reset();
    step(1, 1, 0, 0, 1, 2'h3, 2'h3, 2'h0, 1);
    chk(64'(bus), mk(1, 1, 2'h2, 2'h0));
    chk(64'(bev), 64'h1);
    rst_n = 1'b0;
    #1;
    chk(64'(bus), 64'h0);
    chk(64'(bev), 64'h0);
    repeat (2) @(negedge clk);
    chk(64'(bus), 64'h0);
    rst_n = 1'b1;
    step(1, 1, 0, 0, 0, 2'h1, 2'h0, 2'h1, 0);
    chk(64'(bus), mk(0, 0, 2'h0, 2'h1));
    step(1, 0, 0, 0, 0, 2'h0, 2'h0, 2'h0, 0);
    chk(64'(bus), 64'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    rst_n = 1'b0;
    {en, used, pc, ib, bar, v, s, h, st} = 12'h000;
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    t_barrier();
    t_simd();
    t_hide();
    t_reset();
    tally_and_finish();
  end
endmodule : pmes_event_signal_test
